//--- common/pasd_pkg.sv
// Package for the PWM auto-shutdown and dead-band block: offsets, fields, reset values
package pasd_pkg;

  // Register indices on the plain register port
  localparam logic [1:0] PASD_ADDR_ASD_CTRL = 2'h0;  // auto_shutdown_control
  localparam logic [1:0] PASD_ADDR_EPWM_CTRL = 2'h1;  // enhanced_pwm_control
  localparam logic [1:0] PASD_ADDR_IRQ_STAT = 2'h2;  // Sticky event flags, write one to clear
  localparam logic [1:0] PASD_ADDR_IRQ_MASK = 2'h3;  // Event enables

  // Field positions in auto_shutdown_control
  localparam int PASD_STATUS_BIT = 7;
  localparam int PASD_SRC_LSB    = 4;
  localparam int PASD_AC_LSB     = 2;
  localparam int PASD_BD_LSB     = 0;

  // Field positions in enhanced_pwm_control
  localparam int PASD_RESTART_BIT = 7;
  localparam int PASD_DBC_LSB     = 0;

  // Event flag positions
  localparam int PASD_EVT_SHUTDOWN = 0;
  localparam int PASD_EVT_RESTART  = 1;

  // Values after reset
  localparam logic [7:0] PASD_ASD_CTRL_RST  = 8'h00;
  localparam logic [7:0] PASD_EPWM_CTRL_RST = 8'h00;
  localparam logic [1:0] PASD_IRQ_RST       = 2'h0;

  // Shutdown pin level codes
  localparam logic [1:0] PASD_LVL_LOW  = 2'h0;
  localparam logic [1:0] PASD_LVL_HIGH = 2'h1;

  // Source select code that turns auto-shutdown off
  localparam logic [2:0] PASD_SRC_OFF = 3'h0;

  // Synchroniser depth
  localparam int PASD_SYNC_STAGES = 2;

  // Decoded auto_shutdown_control
  typedef struct packed {
    logic       shutdown_status;         // Outputs held in shutdown
    logic [2:0] shutdown_source_select;  // Trigger choice
    logic [1:0] pair_ac_shutdown_level;  // A and C level in shutdown
    logic [1:0] pair_bd_shutdown_level;  // B and D level in shutdown
  } pasd_asd_ctrl_t;

  // Decoded enhanced_pwm_control
  typedef struct packed {
    logic       auto_restart_enable;  // Hardware clears status
    logic [6:0] dead_band_count;      // Delay in instruction cycles
  } pasd_epwm_ctrl_t;

endpackage : pasd_pkg

//--- verilog/pasd_top.sv
// PWM auto-shutdown, auto-restart and half-bridge dead-band output stage
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pasd_top
  import pasd_pkg::*;
#(
  parameter int DBC_W = 7  // Width of the dead-band counter
) (
  // Clock, reset and enable
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  // Register port
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Shutdown sources from outside the clock domain
  input  wire logic       ext_int_n,
  input  wire logic       comparator_one,
  input  wire logic       comparator_two,
  // Period generator and steering, same clock
  input  wire logic       period_start,
  input  wire logic       half_bridge,
  input  wire logic [3:0] pwm_raw,
  input  wire logic [3:0] pin_enable,
  // Output pins: index 0..3 are pwm_out_a..pwm_out_d
  output logic      [3:0] pwm_out,
  output logic      [3:0] pwm_out_oe,
  // Interrupt
  output logic            irq
);

  // Register state
  pasd_asd_ctrl_t  asd_q;       // auto_shutdown_control
  pasd_epwm_ctrl_t epwm_q;      // enhanced_pwm_control
  logic [1:0]      irq_stat_q;  // Sticky events
  logic [1:0]      irq_mask_q;  // Event enables
  logic [7:0]      rdata_q;     // Read data, one cycle after the strobe

  // Synchronised trigger inputs: bit 0 pin low, 1 comparator one, 2 comparator two
  logic [2:0] trig_raw;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;

  // Shutdown bookkeeping
  logic       hit_sync;   // Selected condition, sampled
  logic       hit_async;  // Selected condition, straight from the pins
  logic       run_q;      // Modulation allowed after a period boundary
  logic       force_sd;   // Pins held at shutdown levels
  logic       wr_asd;     // Write to auto_shutdown_control
  logic       status_set;
  logic       status_clr;
  logic       hw_clear;   // Clear done by auto restart

  // Dead-band paths for A and B
  logic [DBC_W-1:0] db_cnt_q [2];
  logic [1:0]       db_in;
  logic [1:0]       db_out;
  logic [1:0]       db_in_q;

  // Decode the source select against a condition vector
  function automatic logic src_hit(input logic [2:0] sel, input logic [2:0] cond);
    src_hit = (sel[2] & cond[0]) | (sel[0] & cond[1]) | (sel[1] & cond[2]);
  endfunction : src_hit

  assign trig_raw = {comparator_two, comparator_one, ~ext_int_n};

  // Two-stage synchronisers, one per trigger input
  for (genvar gi = 0; gi < 3; gi++) begin : g_sync
    always_ff @(posedge core_clk) begin
      if (!resetn) begin
        sync1_q[gi] <= 1'b0;
        sync2_q[gi] <= 1'b0;
      end else if (clk_en) begin
        sync1_q[gi] <= trig_raw[gi];
        sync2_q[gi] <= sync1_q[gi];
      end
    end
  end

  // Code 000 selects nothing; upper bit adds the pin, lower bits the comparators
  assign hit_sync  = src_hit(asd_q.shutdown_source_select, sync2_q);
  // Unclocked path so the pins react without waiting for an edge
  assign hit_async = src_hit(asd_q.shutdown_source_select, trig_raw);

  assign wr_asd = reg_wr && (reg_addr == PASD_ADDR_ASD_CTRL);

  // Set sources: sampled condition or firmware writing a one
  assign status_set = hit_sync || (wr_asd && reg_wdata[PASD_STATUS_BIT]);
  // Auto clear only while restart enabled and condition gone
  assign hw_clear   = epwm_q.auto_restart_enable && !hit_sync && asd_q.shutdown_status;
  assign status_clr = (wr_asd && !reg_wdata[PASD_STATUS_BIT]) || hw_clear;

  // auto_shutdown_control: set wins over any clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      asd_q <= PASD_ASD_CTRL_RST;
    end else if (clk_en) begin
      if (wr_asd) begin
        asd_q.shutdown_source_select <= reg_wdata[PASD_SRC_LSB +: 3];
        asd_q.pair_ac_shutdown_level <= reg_wdata[PASD_AC_LSB +: 2];
        asd_q.pair_bd_shutdown_level <= reg_wdata[PASD_BD_LSB +: 2];
      end
      if (status_set) begin
        asd_q.shutdown_status <= 1'b1;
      end else if (status_clr) begin
        asd_q.shutdown_status <= 1'b0;
      end
    end
  end

  // enhanced_pwm_control: plain storage
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      epwm_q <= PASD_EPWM_CTRL_RST;
    end else if (clk_en && reg_wr && (reg_addr == PASD_ADDR_EPWM_CTRL)) begin
      epwm_q <= reg_wdata;
    end
  end

  // Interrupt mask
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq_mask_q <= PASD_IRQ_RST;
    end else if (clk_en && reg_wr && (reg_addr == PASD_ADDR_IRQ_MASK)) begin
      irq_mask_q <= reg_wdata[1:0];
    end
  end

  // Sticky events; a new event beats a write-one-to-clear
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq_stat_q <= PASD_IRQ_RST;
    end else if (clk_en) begin
      for (int i = 0; i < 2; i++) begin
        if ((i == PASD_EVT_SHUTDOWN && status_set && !asd_q.shutdown_status) ||
            (i == PASD_EVT_RESTART && hw_clear && !status_set)) begin
          irq_stat_q[i] <= 1'b1;
        end else if (reg_wr && (reg_addr == PASD_ADDR_IRQ_STAT) && reg_wdata[i]) begin
          irq_stat_q[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Read mux; data appears the cycle after the strobe only
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (clk_en && reg_rd) begin
      if (reg_addr == PASD_ADDR_ASD_CTRL) begin
        rdata_q <= asd_q;
      end else if (reg_addr == PASD_ADDR_EPWM_CTRL) begin
        rdata_q <= epwm_q;
      end else if (reg_addr == PASD_ADDR_IRQ_STAT) begin
        rdata_q <= {6'h00, irq_stat_q};
      end else begin
        rdata_q <= {6'h00, irq_mask_q};
      end
    end else if (clk_en) begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // Restart gate: dropped by shutdown, raised only on a period boundary.
  // The period generator keeps counting outside, so the boundary stays aligned.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      run_q <= 1'b0;
    end else if (clk_en) begin
      if (asd_q.shutdown_status || status_set) begin
        run_q <= 1'b0;
      end else if (period_start) begin
        run_q <= 1'b1;
      end
    end
  end

  // Half-bridge feeds A and its complement into the dead band
  assign db_in[0] = pwm_raw[0];
  assign db_in[1] = half_bridge ? ~pwm_raw[0] : pwm_raw[1];

  // Dead band: count instruction cycles after a rising input, release at the count.
  // A falling input clears at once, so a short pulse never shows.
  for (genvar gd = 0; gd < 2; gd++) begin : g_db
    always_ff @(posedge core_clk) begin
      if (!resetn) begin
        db_cnt_q[gd] <= '0;
        db_in_q[gd]  <= 1'b0;
      end else if (clk_en) begin
        db_in_q[gd] <= db_in[gd];
        if (!db_in[gd]) begin
          db_cnt_q[gd] <= '0;
        end else if (db_cnt_q[gd] != epwm_q.dead_band_count[DBC_W-1:0]) begin
          db_cnt_q[gd] <= db_cnt_q[gd] + 1'b1;
        end
      end
    end
    // In half-bridge mode held inactive until the count is reached, even for a whole period; otherwise the input passes straight through
    assign db_out[gd] = half_bridge ?
        (db_in[gd] && db_cnt_q[gd] == epwm_q.dead_band_count[DBC_W-1:0]) :
        db_in[gd];
  end

  // Forced by stored status or at once by the pins
  assign force_sd = asd_q.shutdown_status || hit_async;

  // Pin drive: shutdown level, tri-state, or gated modulation
  always_comb begin
    logic [1:0] lvl;
    lvl = 2'h0;
    for (int p = 0; p < 4; p++) begin
      lvl = (p == 0 || p == 2) ? asd_q.pair_ac_shutdown_level :
                                 asd_q.pair_bd_shutdown_level;
      if (force_sd) begin
        pwm_out[p]    = (lvl == PASD_LVL_HIGH);
        pwm_out_oe[p] = pin_enable[p] && !lvl[1];
      end else begin
        pwm_out[p]    = run_q && ((p < 2) ? db_out[p] : pwm_raw[p]);
        pwm_out_oe[p] = pin_enable[p];
      end
    end
  end

  // Checks kept beside the logic

  a_status_rises: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && hit_sync |=> asd_q.shutdown_status)
    else $error("status did not set on a sampled trigger");

  a_reads_status: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && reg_rd && reg_addr == PASD_ADDR_ASD_CTRL
    |=> reg_rdata[PASD_STATUS_BIT] == $past(asd_q.shutdown_status))
    else $error("status bit read back wrong");

  a_async_level: assert property (@(posedge core_clk) disable iff (!resetn)
    hit_async && asd_q.pair_ac_shutdown_level == PASD_LVL_HIGH && pin_enable[0]
    |-> pwm_out[0] && pwm_out_oe[0])
    else $error("pin A not forced high");

  a_tri_pair: assert property (@(posedge core_clk) disable iff (!resetn)
    asd_q.shutdown_status && asd_q.pair_bd_shutdown_level[1]
    |-> !pwm_out_oe[1] && !pwm_out_oe[3])
    else $error("pair B and D still driven");

  a_auto_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && asd_q.shutdown_status && epwm_q.auto_restart_enable && !hit_sync && !reg_wr
    |=> !asd_q.shutdown_status)
    else $error("auto restart did not clear status");

  a_manual_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    asd_q.shutdown_status && !epwm_q.auto_restart_enable && !(clk_en && wr_asd)
    |=> asd_q.shutdown_status)
    else $error("status cleared without firmware");

  a_boundary_only: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(run_q) |-> $past(period_start) && !$past(asd_q.shutdown_status))
    else $error("modulation resumed off a period boundary");

  // A nonzero count must keep A inactive in the first cycle its input is high
  a_dead_band: assert property (@(posedge core_clk) disable iff (!resetn)
    half_bridge && $rose(db_in[0]) && epwm_q.dead_band_count != 7'h00
    |-> !db_out[0])
    else $error("output A went active before the dead band");

  a_fall_undelayed: assert property (@(posedge core_clk) disable iff (!resetn)
    half_bridge && !force_sd && $fell(db_in[0]) |-> !pwm_out[0])
    else $error("inactive edge was delayed");

  a_irq_level: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && status_set && !asd_q.shutdown_status && irq_mask_q[PASD_EVT_SHUTDOWN]
    |=> irq)
    else $error("interrupt not raised on a shutdown event");

  a_reset_zero: assert property (@(posedge core_clk)
    !resetn |=> asd_q == PASD_ASD_CTRL_RST)
    else $error("control register not zero after reset");

endmodule : pasd_top

`default_nettype wire

//--- testbench/pasd_bridge_model.sv
// Far-side model: period generator, modulated source and shutdown sources
`timescale 1ns/1ps
`default_nettype none

module pasd_bridge_model #(
  parameter int PERIOD = 40,  // Cycles per PWM period
  parameter int DUTY   = 12   // Cycles with source a high
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Trip requests: bit0 comparator one, bit1 comparator two, bit2 pin
  input  wire logic [2:0] trip,
  // Signals towards the block
  output var  logic       period_start,
  output var  logic [3:0] pwm_raw,
  output var  logic       ext_int_n,
  output var  logic       comparator_one,
  output var  logic       comparator_two
);
  int cnt_q;  // Position within the period
  logic wrap;  // Last cycle of a period

  assign wrap = (cnt_q == PERIOD - 1);

  // Quiet values before the first edge
  initial begin
    cnt_q = 0;
    {period_start, pwm_raw, comparator_one, comparator_two} = 7'h00;
    ext_int_n = 1'b1;
  end

  // Free-running period; it never stops for a shutdown
  always @(posedge core_clk) begin
    cnt_q <= (!resetn || wrap) ? 0 : cnt_q + 1;
  end

  // Sources change just after the edge, as real drivers do
  always @(posedge core_clk) begin
    period_start   <= resetn && wrap;
    pwm_raw        <= {3'h0, resetn && (wrap || cnt_q < DUTY - 1)};
    ext_int_n      <= ~trip[2];  // Pin trips when pulled low
    comparator_one <= trip[0];
    comparator_two <= trip[1];
  end
endmodule : pasd_bridge_model

`default_nettype wire

//--- testbench/pasd_top_tb.sv
// Self-checking bench for the auto-shutdown and dead-band stage
`timescale 1ns/1ps
`default_nettype none

module pasd_top_tb;
  import pasd_pkg::*;
  localparam int PER = 40;  // Model period
  localparam int DTY = 12;  // Model duty

  logic       core_clk = 1'b0;
  logic       resetn   = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       half_bridge = 1'b0;
  logic       clk_en = 1'b1;
  logic [3:0] pin_enable = 4'hF;
  logic [2:0] trip = 3'h0;
  wire  [7:0] reg_rdata;
  wire        ext_int_n, comparator_one, comparator_two, period_start, irq;
  wire  [3:0] pwm_raw, pwm_out, pwm_out_oe;
  int         error_cnt = 0;
  int         checks = 0;
  int         cyc = 0;

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  pasd_top uut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_int_n(ext_int_n), .comparator_one(comparator_one),
    .comparator_two(comparator_two), .period_start(period_start),
    .half_bridge(half_bridge), .pwm_raw(pwm_raw), .pin_enable(pin_enable),
    .pwm_out(pwm_out), .pwm_out_oe(pwm_out_oe), .irq(irq));

  pasd_bridge_model #(.PERIOD(PER), .DUTY(DTY)) far (.core_clk(core_clk),
    .resetn(resetn), .trip(trip), .period_start(period_start), .pwm_raw(pwm_raw),
    .ext_int_n(ext_int_n), .comparator_one(comparator_one),
    .comparator_two(comparator_two));

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Data stand only in the cycle after the strobe
  task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic wait_period();
    do @(posedge core_clk); while (period_start !== 1'b1);
  endtask : wait_period

  task automatic t_reset();
    logic [7:0] d;
    for (int a = 0; a < 4; a++) begin
      reg_read(a[1:0], d);
      chk(d, 8'h00);
    end
    chk({7'h0, irq}, 8'h00);
    $display("test reset done");
  endtask : t_reset

  // Every select code against every source
  task automatic t_sources();
    logic [7:0] d;
    logic       hit;
    for (int code = 0; code < 8; code++) begin
      for (int s = 0; s < 3; s++) begin
        hit = code[s];
        reg_write(PASD_ADDR_ASD_CTRL, {1'b0, code[2:0], PASD_LVL_HIGH, PASD_LVL_LOW});
        @(posedge core_clk);
        trip <= 3'h1 << s;
        @(posedge core_clk);
        #1 if (hit) chk({pwm_out_oe, pwm_out}, 8'hF5);
        repeat (4) @(posedge core_clk);
        reg_read(PASD_ADDR_ASD_CTRL, d);
        chk({7'h0, d[7]}, {7'h0, hit});
        @(posedge core_clk);
        trip <= 3'h0;
        repeat (4) @(posedge core_clk);
        reg_read(PASD_ADDR_ASD_CTRL, d);
        chk({7'h0, d[7]}, {7'h0, hit});
        reg_write(PASD_ADDR_ASD_CTRL, 8'h00);
        reg_read(PASD_ADDR_ASD_CTRL, d);
        chk(d, 8'h00);
        reg_write(PASD_ADDR_IRQ_STAT, 8'h03);
      end
    end
    $display("test sources done");
  endtask : t_sources

  // Firmware trip with each pair tri-stated in turn; pin C disabled in the second pass
  task automatic t_levels();
    logic [7:0] d;
    logic [7:0] ctl;
    logic [3:0] pen;
    logic [7:0] exp;
    for (int k = 0; k < 2; k++) begin
      ctl = (k == 0) ? 8'h89 : 8'h86;
      pen = (k == 0) ? 4'hF : 4'hB;
      exp = (k == 0) ? 8'hAA : 8'h11;
      reg_write(PASD_ADDR_ASD_CTRL, ctl);
      pin_enable <= pen;
      #1 chk({pwm_out_oe, pwm_out & pwm_out_oe}, exp);
      reg_read(PASD_ADDR_ASD_CTRL, d);
      chk(d, ctl);
      reg_write(PASD_ADDR_ASD_CTRL, 8'h00);
      reg_write(PASD_ADDR_IRQ_STAT, 8'h03);
    end
    pin_enable <= 4'hF;
    $display("test levels done");
  endtask : t_levels

  // A firmware trip written while the enable is low must not land
  task automatic t_freeze();
    logic [7:0] d;
    clk_en <= 1'b0;
    reg_write(PASD_ADDR_ASD_CTRL, 8'h80);
    clk_en <= 1'b1;
    reg_read(PASD_ADDR_ASD_CTRL, d);
    chk(d, 8'h00);
    $display("test freeze done");
  endtask : t_freeze

  // Hardware restart, interrupt and period alignment
  task automatic t_restart();
    logic [7:0] d;
    reg_write(PASD_ADDR_IRQ_MASK, 8'h03);
    reg_write(PASD_ADDR_EPWM_CTRL, 8'h80);
    reg_write(PASD_ADDR_ASD_CTRL, 8'h20);
    trip <= 3'h2;
    repeat (6) @(posedge core_clk);
    reg_read(PASD_ADDR_ASD_CTRL, d);
    chk(d, 8'hA0);
    chk({7'h0, irq}, 8'h01);
    wait_period();
    trip <= 3'h0;
    repeat (6) @(posedge core_clk);
    reg_read(PASD_ADDR_ASD_CTRL, d);
    chk(d, 8'h20);
    chk({6'h0, pwm_raw[0], pwm_out[0]}, 8'h02);
    reg_read(PASD_ADDR_IRQ_STAT, d);
    chk(d, 8'h03);
    wait_period();
    repeat (2) @(posedge core_clk);
    #1 chk({7'h0, pwm_out[0]}, 8'h01);
    reg_write(PASD_ADDR_IRQ_STAT, 8'h03);
    #1 chk({7'h0, irq}, 8'h00);
    $display("test restart done");
  endtask : t_restart

  // Dead band below and above the duty
  task automatic t_deadband(input int dbc);
    int la, ha, lb, bad;
    la = 0;
    ha = 0;
    lb = 0;
    bad = 0;
    reg_write(PASD_ADDR_EPWM_CTRL, dbc[7:0]);
    half_bridge <= 1'b1;
    wait_period();
    wait_period();
    for (int i = 0; i < PER; i++) begin
      @(posedge core_clk);
      #1;
      la += (pwm_raw[0] && !pwm_out[0]);
      ha += pwm_out[0];
      lb += (!pwm_raw[0] && !pwm_out[1]);
      bad += (pwm_raw[0] == pwm_out[1]) && pwm_out[1];
      bad += !pwm_raw[0] && pwm_out[0];
    end
    chk(la[7:0], (dbc < DTY ? dbc[7:0] : DTY[7:0]));
    chk(ha[7:0], (dbc < DTY ? DTY[7:0] - dbc[7:0] : 8'h00));
    chk(lb[7:0], dbc[7:0]);
    chk(bad[7:0], 8'h00);
    $display("test deadband %0d done", dbc);
  endtask : t_deadband

  task automatic print_verdict();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_sources();
    t_levels();
    t_freeze();
    t_restart();
    t_deadband(3);
    t_deadband(14);
    print_verdict();
  end
endmodule : pasd_top_tb

`default_nettype wire
